// ### hdl/obm_device.sv
// Memory subsystem end: programmable store, security register, boot copy and tile SRAM.
`timescale 1ns/1ps

// Function
// R1 - Store is 8 KB: four sectors of 512x32.
// R2 - Security register loaded from store at power-up.
// R3 - Remaining store copied to SRAM, executed first.
// R4 - Row address through 16-bit port 0x100200.
// R5 - Program data through 32-bit port 0x200100.
// R6 - Programming control through 16-bit port 0x100300.
// R7 - One shared 32-bit SRAM bank.
// R8 - Fetches of 16 or 32 bits accepted.
// R9 - Byte, half, word access in one cycle.
// R10 - Async low reset, wait PLL lock, boot.
// R11 - Reset held low 100 ns after power-up.
// R12 - Bits 8 to 11 lock sectors 0 to 3.
// R13 - Bit 12 locks all programming, security too.
// R14 - Bit 5 forces boot from store address 0.
// R15 - Locked write no effect; bits never revert.
// R16 - SRAM access held off until copy done.
module obm_device
    import obm_pkg::*;
(
    obm_if.device            bus,
    input  wire logic        I_CLOCK,
    input  wire logic        I_PLL_LOCK,
    output logic             O_BOOT_DONE,
    output logic             O_SECURE_BOOT,
    output logic [31:0]      O_SEC_REG
);

    typedef enum logic [3:0] {
        S_LOCK = 4'h1,
        S_LOAD = 4'h2,
        S_COPY = 4'h4,
        S_RUN  = 4'h8
    } obm_boot_t;

    obm_boot_t              state;
    logic [COPY_CNT_W-1:0]  copy_idx;
    logic [31:0]            sec_reg;
    logic [15:0]            row_addr;
    logic [31:0]            prog_word;
    // The store is nonvolatile: it has no reset and starts out erased.
    logic [OTP_WORD_W-1:0]  otp_mem [OTP_WORDS] = '{default: '0};
    logic [OTP_WORD_W-1:0]  otp_sec = '0;
    logic [31:0]            sram [SRAM_WORDS];
    logic                   prog_fire;
    logic                   prog_ok;
    logic                   acc_take;
    logic                   acc_bad;
    logic [BYTE_LANES-1:0]  lane_en;
    logic [31:0]            lane_data;
    logic [31:0]            rd_word;
    logic [31:0]            rd_shift;
    logic [SRAM_IDX_W-1:0]  word_idx;
    logic [1:0]             sub;

    ////////////////////////////////////////////////////////////////////////////////
    // Boot sequence.

    always_ff @(posedge I_CLOCK or negedge bus.rst_n) begin
        if (!bus.rst_n) begin // R10
            state <= S_LOCK;
        end else begin
            unique case (state)
                S_LOCK: begin
                    if (I_PLL_LOCK) begin // R10
                        state <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    state <= S_COPY;
                end
                S_COPY: begin
                    if (copy_idx == COPY_LAST) begin // R3
                        state <= S_RUN;
                    end
                end
                S_RUN: begin
                    state <= S_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLOCK or negedge bus.rst_n) begin
        if (!bus.rst_n) begin
            copy_idx <= '0;
        end else if (state == S_COPY) begin
            copy_idx <= copy_idx + 12'h001; // R3
        end
    end

    always_ff @(posedge I_CLOCK or negedge bus.rst_n) begin
        if (!bus.rst_n) begin
            sec_reg <= SEC_RESET;
        end else if (state == S_LOAD) begin
            sec_reg <= otp_sec; // R2
        end
    end

    // The copied image sits at SRAM address 0, so secure boot starts the
    // processor at store address 0 instead of the boot ROM.
    always_ff @(posedge I_CLOCK or negedge bus.rst_n) begin
        if (!bus.rst_n) begin
            bus.boot_done     <= 1'b0;
            bus.boot_from_otp <= 1'b0;
        end else begin
            bus.boot_done     <= (state == S_RUN); // R16
            bus.boot_from_otp <= (state == S_RUN) && sec_reg[SEC_SECURE_BOOT]; // R14
        end
    end

    assign O_BOOT_DONE   = bus.boot_done;
    assign O_SECURE_BOOT = bus.boot_from_otp;
    assign O_SEC_REG     = sec_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Programming ports.

    always_ff @(posedge I_CLOCK or negedge bus.rst_n) begin
        if (!bus.rst_n) begin
            row_addr  <= 16'h0000;
            prog_word <= 32'h0000_0000;
        end else if (bus.port_wr) begin
            if (bus.port_id == RES_OTP_ADDR) begin
                row_addr <= bus.port_data[OTP_ADDR_PORT_W-1:0]; // R4
            end
            if (bus.port_id == RES_OTP_DATA) begin
                prog_word <= bus.port_data; // R5
            end
        end
    end

    // Locks come from the live security register, so a newly programmed lock
    // word takes effect only after the next power-up load.
    always_comb begin
        prog_fire = bus.port_wr && (bus.port_id == RES_OTP_CTRL)
                    && bus.port_data[CTRL_PROGRAM_BIT] && (state == S_RUN); // R6
        if (sec_reg[SEC_MASTER_LOCK]) begin
            prog_ok = 1'b0; // R13
        end else if (row_addr == OTP_SEC_ADDR) begin
            prog_ok = 1'b1;
        end else if (row_addr < OTP_SEC_ADDR) begin
            prog_ok = !sec_reg[SEC_SECTOR_LOCK0 + row_addr[OTP_IDX_W-1:OTP_ROW_W]]; // R12
        end else begin
            prog_ok = 1'b0;
        end
    end

    always_ff @(posedge I_CLOCK or negedge bus.rst_n) begin
        if (!bus.rst_n) begin
            bus.prog_done <= 1'b0;
            bus.prog_err  <= 1'b0;
        end else begin
            bus.prog_done <= prog_fire;
            bus.prog_err  <= prog_fire && !prog_ok; // R15
        end
    end

    // Programming only ORs ones in, so a programmed bit never returns to zero.
    always_ff @(posedge I_CLOCK) begin
        if (prog_fire && prog_ok) begin // R15
            if (row_addr == OTP_SEC_ADDR) begin
                otp_sec <= otp_sec | prog_word;
            end else begin
                otp_mem[row_addr[OTP_IDX_W-1:0]] <= otp_mem[row_addr[OTP_IDX_W-1:0]]
                                                    | prog_word; // R1
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Tile SRAM access.

    always_comb begin
        word_idx  = bus.mem_addr[SRAM_ADDR_W-1:2];
        sub       = bus.mem_addr[1:0];
        acc_take  = bus.mem_req && (state == S_RUN); // R16
        unique case (bus.mem_size)
            SIZE_BYTE: acc_bad = bus.mem_fetch;
            SIZE_HALF: acc_bad = sub[0];
            SIZE_WORD: acc_bad = (sub != 2'h0);
            default:   acc_bad = 1'b1;
        endcase
        if (bus.mem_fetch && bus.mem_we) begin
            acc_bad = 1'b1; // R8
        end
        unique case (bus.mem_size)
            SIZE_BYTE: lane_data = {4{bus.mem_wdata[7:0]}};
            SIZE_HALF: lane_data = {2{bus.mem_wdata[15:0]}};
            default:   lane_data = bus.mem_wdata;
        endcase
        rd_word  = sram[word_idx];
        rd_shift = rd_word >> {sub, 3'h0};
    end

    // Byte enables: one lane per byte of the 32-bit word.
    for (genvar l = 0; l < BYTE_LANES; l++) begin : g_lane
        always_comb begin
            unique case (bus.mem_size)
                SIZE_BYTE: lane_en[l] = (sub == 2'(l)); // R9
                SIZE_HALF: lane_en[l] = (sub[1] == 1'(l / 2));
                default:   lane_en[l] = 1'b1;
            endcase
        end
    end

    // A single write port serves both the boot copy and the processor, which
    // cannot collide because the processor is held off during the copy.
    always_ff @(posedge I_CLOCK) begin
        if (state == S_COPY) begin
            sram[copy_idx] <= otp_mem[copy_idx[OTP_IDX_W-1:0]]; // R3
        end else if (acc_take && bus.mem_we && !acc_bad) begin
            for (int b = 0; b < BYTE_LANES; b++) begin
                if (lane_en[b]) begin
                    sram[word_idx][8*b +: 8] <= lane_data[8*b +: 8]; // R7
                end
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge bus.rst_n) begin
        if (!bus.rst_n) begin
            bus.mem_ack   <= 1'b0;
            bus.mem_err   <= 1'b0;
            bus.mem_rdata <= 32'h0000_0000;
        end else begin
            bus.mem_ack <= acc_take; // R9
            bus.mem_err <= acc_take && acc_bad;
            if (acc_take && !bus.mem_we && !acc_bad) begin
                unique case (bus.mem_size)
                    SIZE_BYTE: bus.mem_rdata <= {24'h00_0000, rd_shift[7:0]};
                    SIZE_HALF: bus.mem_rdata <= {16'h0000, rd_shift[15:0]}; // R8
                    default:   bus.mem_rdata <= rd_word;
                endcase
            end
        end
    end

endmodule // obm_device

// ### shared/obm_pkg.sv
// Shared constants for the one-time-programmable store and tile SRAM subsystem.
package obm_pkg;

    // One-time-programmable store geometry.
    localparam int unsigned OTP_SECTORS   = 4;
    localparam int unsigned OTP_ROWS      = 512;
    localparam int unsigned OTP_WORD_W    = 32;
    localparam int unsigned OTP_WORDS     = OTP_SECTORS * OTP_ROWS;
    localparam int unsigned OTP_IDX_W     = 11;
    localparam int unsigned OTP_ROW_W     = 9;
    localparam int unsigned COPY_CNT_W    = 12;
    localparam logic [COPY_CNT_W-1:0] COPY_LAST = 12'h7FF;

    // Row address 0x0800 selects the security register word of the store.
    localparam logic [15:0] OTP_SEC_ADDR  = 16'h0800;

    // Resource numbers of the three programming ports and their widths.
    localparam logic [31:0] RES_OTP_ADDR  = 32'h0010_0200;
    localparam logic [31:0] RES_OTP_DATA  = 32'h0020_0100;
    localparam logic [31:0] RES_OTP_CTRL  = 32'h0010_0300;
    localparam int unsigned OTP_ADDR_PORT_W = 16;
    localparam int unsigned OTP_CTRL_PORT_W = 16;

    // Control port field: writing a one here programs the addressed row.
    localparam int unsigned CTRL_PROGRAM_BIT = 0;

    // Security register fields and reset value.
    localparam int unsigned SEC_SECURE_BOOT  = 5;
    localparam int unsigned SEC_SECTOR_LOCK0 = 8;
    localparam int unsigned SEC_MASTER_LOCK  = 12;
    localparam logic [31:0] SEC_RESET        = 32'h0000_0000;

    // Tile SRAM: one 128 KB bank of 32-bit words, byte addressed.
    localparam int unsigned SRAM_WORDS    = 32768;
    localparam int unsigned SRAM_ADDR_W   = 17;
    localparam int unsigned SRAM_IDX_W    = 15;
    localparam int unsigned BYTE_LANES    = 4;

    // Access size codes.
    localparam logic [1:0]  SIZE_BYTE     = 2'h0;
    localparam logic [1:0]  SIZE_HALF     = 2'h1;
    localparam logic [1:0]  SIZE_WORD     = 2'h2;

    // Reset hold after power-up, 100 ns at a 5 ns clock, rounded up.
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned RST_HOLD_NS   = 100;
    localparam int unsigned RST_HOLD_CYC  = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
    localparam int unsigned RST_CNT_W     = 6;

endpackage

// ### shared/obm_if.sv
// Link between the tile processor end and the memory subsystem end.
`timescale 1ns/1ps
interface obm_if (
    input wire logic clk
);
    logic        rst_n;
    logic        port_wr;
    logic [31:0] port_id;
    logic [31:0] port_data;
    logic        prog_done;
    logic        prog_err;
    logic        mem_req;
    logic        mem_we;
    logic        mem_fetch;
    logic [1:0]  mem_size;
    logic [16:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata;
    logic        mem_ack;
    logic        mem_err;
    logic        boot_done;
    logic        boot_from_otp;

    modport device (
        input  clk, rst_n, port_wr, port_id, port_data,
        input  mem_req, mem_we, mem_fetch, mem_size, mem_addr, mem_wdata,
        output prog_done, prog_err, mem_rdata, mem_ack, mem_err,
        output boot_done, boot_from_otp
    );

    modport host (
        input  clk, prog_done, prog_err, mem_rdata, mem_ack, mem_err,
        input  boot_done, boot_from_otp,
        output rst_n, port_wr, port_id, port_data,
        output mem_req, mem_we, mem_fetch, mem_size, mem_addr, mem_wdata
    );
endinterface

// ### hdl/obm_host.sv
// Tile processor end: reset hold, programming sequencer and SRAM requester.
`timescale 1ns/1ps
module obm_host
    import obm_pkg::*;
(
    obm_if.host              bus,
    input  wire logic        I_CLOCK,
    input  wire logic        I_SYS_RST_N,
    input  wire logic        I_PROG_REQ,
    input  wire logic [15:0] I_PROG_ADDR,
    input  wire logic [31:0] I_PROG_DATA,
    output logic             O_PROG_BUSY,
    output logic             O_PROG_DONE,
    output logic             O_PROG_ERR,
    input  wire logic        I_ACC_REQ,
    input  wire logic        I_ACC_WE,
    input  wire logic        I_ACC_FETCH,
    input  wire logic [1:0]  I_ACC_SIZE,
    input  wire logic [16:0] I_ACC_ADDR,
    input  wire logic [31:0] I_ACC_WDATA,
    output logic             O_ACC_DONE,
    output logic             O_ACC_ERR,
    output logic [31:0]      O_ACC_RDATA,
    output logic             O_READY
);

    typedef enum logic [4:0] {
        H_IDLE = 5'h01,
        H_ADDR = 5'h02,
        H_DATA = 5'h04,
        H_CTRL = 5'h08,
        H_WAIT = 5'h10
    } obm_prog_t;

    obm_prog_t             state;
    logic [RST_CNT_W-1:0]  rst_cnt;
    logic [15:0]           p_addr;
    logic [31:0]           p_data;
    logic                  acc_wait;

    ////////////////////////////////////////////////////////////////////////////////
    // Subsystem reset: held low through power-up and 100 ns beyond.

    always_ff @(posedge I_CLOCK or negedge I_SYS_RST_N) begin
        if (!I_SYS_RST_N) begin
            rst_cnt   <= '0;
            bus.rst_n <= 1'b0;
        end else if (rst_cnt != RST_CNT_W'(RST_HOLD_CYC)) begin
            rst_cnt   <= rst_cnt + 6'h01; // R11
        end else begin
            bus.rst_n <= 1'b1; // R11
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Programming: address, then data, then control, then wait for the answer.

    always_ff @(posedge I_CLOCK or negedge I_SYS_RST_N) begin
        if (!I_SYS_RST_N) begin
            state         <= H_IDLE;
            p_addr        <= 16'h0000;
            p_data        <= 32'h0000_0000;
            bus.port_wr   <= 1'b0;
            bus.port_id   <= 32'h0000_0000;
            bus.port_data <= 32'h0000_0000;
            O_PROG_BUSY   <= 1'b0;
            O_PROG_DONE   <= 1'b0;
            O_PROG_ERR    <= 1'b0;
        end else begin
            bus.port_wr <= 1'b0;
            O_PROG_DONE <= 1'b0;
            unique case (state)
                H_IDLE: begin
                    if (I_PROG_REQ && bus.boot_done) begin
                        p_addr      <= I_PROG_ADDR;
                        p_data      <= I_PROG_DATA;
                        O_PROG_BUSY <= 1'b1;
                        state       <= H_ADDR;
                    end
                end
                H_ADDR: begin
                    bus.port_wr   <= 1'b1;
                    bus.port_id   <= RES_OTP_ADDR; // R4
                    bus.port_data <= {16'h0000, p_addr};
                    state         <= H_DATA;
                end
                H_DATA: begin
                    bus.port_wr   <= 1'b1;
                    bus.port_id   <= RES_OTP_DATA; // R5
                    bus.port_data <= p_data;
                    state         <= H_CTRL;
                end
                H_CTRL: begin
                    bus.port_wr   <= 1'b1;
                    bus.port_id   <= RES_OTP_CTRL; // R6
                    bus.port_data <= 32'h0000_0001;
                    state         <= H_WAIT;
                end
                H_WAIT: begin
                    if (bus.prog_done) begin
                        O_PROG_DONE <= 1'b1;
                        O_PROG_ERR  <= bus.prog_err;
                        O_PROG_BUSY <= 1'b0;
                        state       <= H_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // SRAM requests, issued only once the boot copy has finished.

    always_ff @(posedge I_CLOCK or negedge I_SYS_RST_N) begin
        if (!I_SYS_RST_N) begin
            bus.mem_req   <= 1'b0;
            bus.mem_we    <= 1'b0;
            bus.mem_fetch <= 1'b0;
            bus.mem_size  <= SIZE_WORD;
            bus.mem_addr  <= 17'h0_0000;
            bus.mem_wdata <= 32'h0000_0000;
            acc_wait      <= 1'b0;
            O_ACC_DONE    <= 1'b0;
            O_ACC_ERR     <= 1'b0;
            O_ACC_RDATA   <= 32'h0000_0000;
            O_READY       <= 1'b0;
        end else begin
            bus.mem_req <= 1'b0;
            O_ACC_DONE  <= 1'b0;
            O_READY     <= bus.boot_done && !acc_wait && !bus.mem_req;
            if (I_ACC_REQ && O_READY) begin // R16
                bus.mem_req   <= 1'b1;
                bus.mem_we    <= I_ACC_WE;
                bus.mem_fetch <= I_ACC_FETCH;
                bus.mem_size  <= I_ACC_SIZE;
                bus.mem_addr  <= I_ACC_ADDR;
                bus.mem_wdata <= I_ACC_WDATA;
                acc_wait      <= 1'b1;
                O_READY       <= 1'b0;
            end else if (acc_wait && bus.mem_ack) begin
                acc_wait    <= 1'b0;
                O_ACC_DONE  <= 1'b1;
                O_ACC_ERR   <= bus.mem_err;
                O_ACC_RDATA <= bus.mem_rdata;
            end
        end
    end

endmodule // obm_host

// ### tb/obm_checker.sv
// Concurrent checks on the link between the processor end and the memory end.
`timescale 1ns/1ps
module obm_checker
    import obm_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        port_wr,
    input wire logic [31:0] port_id,
    input wire logic [31:0] port_data,
    input wire logic        prog_done,
    input wire logic        prog_err,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic        mem_fetch,
    input wire logic [1:0]  mem_size,
    input wire logic [16:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic        mem_ack,
    input wire logic        mem_err,
    input wire logic        boot_done,
    input wire logic        boot_from_otp
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    a_ack_one_cycle: assert property (mem_req && boot_done |=> mem_ack)
        else $error("memory request not answered in one cycle");
    a_ack_has_req: assert property (mem_ack |-> $past(mem_req))
        else $error("memory answer without a request");
    a_err_with_ack: assert property (mem_err |-> mem_ack)
        else $error("memory error outside an answer");
    a_word_misalign: assert property (mem_req && boot_done && mem_size == SIZE_WORD
        && mem_addr[1:0] != 2'h0 |=> mem_err)
        else $error("misaligned word access not refused");
    a_fetch_byte_err: assert property (mem_req && boot_done && mem_fetch
        && mem_size == SIZE_BYTE |=> mem_err)
        else $error("byte fetch not refused");
    a_fetch_half_ok: assert property (mem_req && boot_done && mem_fetch && !mem_we
        && mem_size == SIZE_HALF && !mem_addr[0] |=> !mem_err)
        else $error("aligned half fetch refused");
    a_prog_answer: assert property (port_wr && port_id == RES_OTP_CTRL && port_data[0]
        && boot_done |=> prog_done)
        else $error("program command not answered next cycle");
    a_done_has_ctrl: assert property (prog_done |-> $past(port_wr)
        && $past(port_id) == RES_OTP_CTRL)
        else $error("program answer without a control write");
    a_boot_holds: assert property (boot_done |=> boot_done)
        else $error("boot complete flag dropped");
    a_no_early_ack: assert property (!boot_done |-> !mem_ack)
        else $error("memory answered before boot copy completed");
    a_secure_steady: assert property (boot_done && $past(boot_done)
        |-> $stable(boot_from_otp))
        else $error("secure boot flag changed while running");
endmodule // obm_checker

// ### tb/otp_boot_memory_bench.sv
// Self-checking bench joining the processor end and the memory end.
`timescale 1ns/1ps
module otp_boot_memory_bench
    import obm_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        pll_lock = 1'b0;
    logic        prog_req = 1'b0;
    logic [15:0] prog_addr = 16'h0000;
    logic [31:0] prog_data = 32'h0000_0000;
    logic        acc_req = 1'b0;
    logic        acc_we = 1'b0;
    logic        acc_fetch = 1'b0;
    logic [1:0]  acc_size = 2'h2;
    logic [16:0] acc_addr = 17'h00000;
    logic [31:0] acc_wdata = 32'h0000_0000;
    logic        boot_done, secure_boot, prog_busy, prog_done, prog_err;
    logic        acc_done, acc_err, ready;
    logic [31:0] sec_reg, acc_rdata;
    int          err_count = 0;
    int          checks_done = 0;

    always #2.5 clk = ~clk;

    obm_if bus (.clk(clk));
    obm_device obm_device_inst (.bus(bus), .I_CLOCK(clk), .I_PLL_LOCK(pll_lock),
        .O_BOOT_DONE(boot_done), .O_SECURE_BOOT(secure_boot), .O_SEC_REG(sec_reg));
    obm_host obm_host_inst (.bus(bus), .I_CLOCK(clk), .I_SYS_RST_N(rst_n),
        .I_PROG_REQ(prog_req), .I_PROG_ADDR(prog_addr), .I_PROG_DATA(prog_data),
        .O_PROG_BUSY(prog_busy), .O_PROG_DONE(prog_done), .O_PROG_ERR(prog_err),
        .I_ACC_REQ(acc_req), .I_ACC_WE(acc_we), .I_ACC_FETCH(acc_fetch),
        .I_ACC_SIZE(acc_size), .I_ACC_ADDR(acc_addr), .I_ACC_WDATA(acc_wdata),
        .O_ACC_DONE(acc_done), .O_ACC_ERR(acc_err), .O_ACC_RDATA(acc_rdata),
        .O_READY(ready));
    obm_checker obm_checker_inst (.clk(bus.clk), .rst_n(bus.rst_n), .port_wr(bus.port_wr),
        .port_id(bus.port_id), .port_data(bus.port_data), .prog_done(bus.prog_done),
        .prog_err(bus.prog_err), .mem_req(bus.mem_req), .mem_we(bus.mem_we),
        .mem_fetch(bus.mem_fetch), .mem_size(bus.mem_size), .mem_addr(bus.mem_addr),
        .mem_wdata(bus.mem_wdata), .mem_rdata(bus.mem_rdata), .mem_ack(bus.mem_ack),
        .mem_err(bus.mem_err), .boot_done(bus.boot_done),
        .boot_from_otp(bus.boot_from_otp));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // The lock is withheld for a while so that an early boot would show.
    task automatic boot();
        int n;
        @(negedge clk);
        rst_n = 1'b0;
        pll_lock = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (20) @(negedge clk);
        check({31'h0, bus.rst_n}, 32'h0);
        @(negedge clk);
        check({31'h0, bus.rst_n}, 32'h1);
        repeat (19) @(negedge clk);
        check({31'h0, boot_done}, 32'h0);
        check({31'h0, ready}, 32'h0);
        pll_lock = 1'b1;
        n = 0;
        while (ready !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        check({31'h0, ready}, 32'h1);
    endtask

    task automatic prog(input logic [15:0] a, input logic [31:0] d, input logic ee);
        int n;
        prog_addr = a;
        prog_data = d;
        prog_req = 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (prog_busy !== 1'b1 && n < 20);
        prog_req = 1'b0;
        while (prog_done !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check({31'h0, prog_done}, 32'h1);
        check({31'h0, prog_err}, {31'h0, ee});
        check({31'h0, prog_busy}, 32'h0);
    endtask

    task automatic acc(input logic we, input logic f, input logic [1:0] s,
                       input logic [16:0] a, input logic [31:0] wd,
                       input logic ee, input logic [31:0] er);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        {acc_we, acc_fetch, acc_size, acc_addr, acc_wdata} = {we, f, s, a, wd};
        acc_req = 1'b1;
        @(negedge clk);
        acc_req = 1'b0;
        while (acc_done !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check({31'h0, acc_done}, 32'h1);
        check({31'h0, acc_err}, {31'h0, ee});
        if (!we && !ee) begin
            check(acc_rdata, er);
        end
    endtask

    initial begin
        #200000;
        err_count++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        boot();
        acc(1'b0, 1'b0, SIZE_WORD, 17'h00004, 32'h0, 1'b0, 32'h0000_0000);
        acc(1'b1, 1'b0, SIZE_WORD, 17'h04000, 32'h1122_3344, 1'b0, 32'h0);
        acc(1'b0, 1'b0, SIZE_BYTE, 17'h04001, 32'h0, 1'b0, 32'h0000_0033);
        acc(1'b0, 1'b0, SIZE_HALF, 17'h04002, 32'h0, 1'b0, 32'h0000_1122);
        acc(1'b1, 1'b0, SIZE_BYTE, 17'h04003, 32'h0000_00AB, 1'b0, 32'h0);
        acc(1'b1, 1'b0, SIZE_HALF, 17'h04000, 32'h0000_5566, 1'b0, 32'h0);
        acc(1'b0, 1'b0, SIZE_WORD, 17'h04000, 32'h0, 1'b0, 32'hAB22_5566);
        acc(1'b0, 1'b1, SIZE_HALF, 17'h04002, 32'h0, 1'b0, 32'h0000_AB22);
        acc(1'b0, 1'b1, SIZE_WORD, 17'h04000, 32'h0, 1'b0, 32'hAB22_5566);
        acc(1'b0, 1'b0, SIZE_WORD, 17'h04001, 32'h0, 1'b1, 32'h0);
        acc(1'b1, 1'b0, SIZE_HALF, 17'h04001, 32'h0, 1'b1, 32'h0);
        acc(1'b0, 1'b1, SIZE_BYTE, 17'h04000, 32'h0, 1'b1, 32'h0);
        acc(1'b1, 1'b1, SIZE_WORD, 17'h04000, 32'h0, 1'b1, 32'h0);
        acc(1'b0, 1'b0, 2'h3, 17'h04000, 32'h0, 1'b1, 32'h0);
        acc(1'b0, 1'b0, SIZE_WORD, 17'h04000, 32'h0, 1'b0, 32'hAB22_5566);
        $display("test sram_access done");
        prog(16'h0001, 32'h1234_5678, 1'b0);
        prog(16'h0001, 32'h0000_000F, 1'b0);
        prog(16'h07FF, 32'hA5A5_A5A5, 1'b0);
        prog(16'h0801, 32'h0000_0001, 1'b1);
        prog(OTP_SEC_ADDR, 32'h0000_0120, 1'b0);
        check(sec_reg, 32'h0000_0000);
        acc(1'b1, 1'b0, SIZE_WORD, 17'h00004, 32'hDEAD_BEEF, 1'b0, 32'h0);
        $display("test program_rows done");
        boot();
        check(sec_reg, 32'h0000_0120);
        check({31'h0, secure_boot}, 32'h1);
        acc(1'b0, 1'b0, SIZE_WORD, 17'h00004, 32'h0, 1'b0, 32'h1234_567F);
        acc(1'b0, 1'b0, SIZE_WORD, 17'h01FFC, 32'h0, 1'b0, 32'hA5A5_A5A5);
        prog(16'h0002, 32'h0000_0001, 1'b1);
        prog(16'h0200, 32'h0000_0001, 1'b0);
        prog(OTP_SEC_ADDR, 32'h0000_1000, 1'b0);
        $display("test sector_lock done");
        boot();
        check(sec_reg, 32'h0000_1120);
        prog(16'h0400, 32'h0000_0001, 1'b1);
        prog(OTP_SEC_ADDR, 32'h0000_0001, 1'b1);
        acc(1'b0, 1'b0, SIZE_WORD, 17'h00008, 32'h0, 1'b0, 32'h0000_0000);
        acc(1'b0, 1'b0, SIZE_WORD, 17'h00800, 32'h0, 1'b0, 32'h0000_0001);
        $display("test master_lock done");
        summarize();
    end
endmodule // otp_boot_memory_bench
